// [sim/dis_exec_asserts.sv]
/*
  port-level checks on the execute stage.
  assumes binding into dis_exec, one clock, synchronous active-high reset.
*/
`timescale 1ns/1ns
module dis_exec_asserts (
  input wire logic               clk,
  input wire logic               rst,
  input wire dis_pkg::dis_instr_t instr,
  input wire logic               resume,
  input wire logic [39:0]        acc,
  input wire logic [15:0]        product_upper,
  input wire logic [15:0]        product_lower,
  input wire logic [15:0]        pc,
  input wire logic [31:0]        loop_view,
  input wire logic               halted,
  input wire logic               instr_ready
);
  import dis_pkg::*;
  logic take;
  // false conditions are checked apart, so most checks need cond_ok
  assign take = instr.valid && instr_ready && instr.cond_ok;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence halt_issue;
    instr.valid && instr_ready && instr.op == OP_HALT;
  endsequence
  sequence parked;
    halted && !instr_ready;
  endsequence
  jump_target_a: assert property (
    take && instr.op inside {OP_JUMP_COND, OP_CALL} |=> pc == $past(instr.program_target)
  ) else $error("jump target not loaded");
  false_cond_a: assert property (
    instr.valid && instr_ready && !instr.cond_ok
    && instr.op inside {OP_JUMP_COND, OP_CALL, OP_INVERT_ACC, OP_PRODUCT_SUM,
                        OP_PRODUCT_SUBTRACT, OP_COUNT_DOWN_ACC, OP_COUNT_DOWN_REG,
                        OP_COUNT_DOWN_MEM, OP_ABSOLUTE_VALUE}
    |=> pc == $past(pc) + 16'h0001 && $stable(acc)) else $error("false condition changed state");
  mask_upper_a: assert property (
    take && instr.op == OP_MASK_LITERAL
    |=> acc == ($past(acc) & {8'hff, $past(instr.operand), 16'hffff})) else $error("mask wrong");
  mask_short_a: assert property (
    take && instr.op == OP_MASK_UNSIGNED_SHORT
    |=> acc == ($past(acc) & {18'h3fc00, $past(instr.short_literal), 16'hffff})
  ) else $error("short mask not zero-extended");
  compare_keeps_a: assert property (
    take && instr.op inside {OP_COMPARE_OP, OP_PRODUCT_COMPARE} |=> $stable(acc)
  ) else $error("compare altered accumulator");
  halt_stops_a: assert property (
    halt_issue |=> parked and pc == $past(pc)) else $error("halt did not stop");
  halt_holds_a: assert property (
    (parked and !resume) |=> parked ##0 ($stable(pc) && $stable(acc))
  ) else $error("ran while halted");
  resume_runs_a: assert property (
    (parked and resume) |=> instr_ready) else $error("resume ignored");
  product_sum_a: assert property (
    take && instr.op == OP_PRODUCT_SUM |=> acc == $past(acc)
      + {{8{$past(product_upper[15])}}, $past(product_upper), $past(product_lower)}
  ) else $error("product sum wrong");
  loop_idle_a: assert property (
    take && instr.op == OP_LOOP_BRANCH_NONZERO
    && (instr.loop_sel ? loop_view[31:16] : loop_view[15:0]) == 16'h0000
    |=> pc == $past(pc) + 16'h0001) else $error("loop branch on zero counter");
endmodule
bind dis_exec dis_exec_asserts u_chk (.clk(clk), .rst(rst), .instr(instr), .resume(resume),
  .acc(acc), .product_upper(product_upper), .product_lower(product_lower), .pc(pc),
  .loop_view(loop_view), .halted(halted), .instr_ready(instr_ready));

// [sim/dis_exec_test.sv]
/*
  self-checking bench for the execute stage.
  assumes the package and params header are compiled first.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module dis_exec_test;
  import dis_pkg::*;
  logic        clk, rst, resume, halted, instr_ready;
  dis_instr_t  instr;
  logic [39:0] acc;
  logic [15:0] pu, pl, pc, reg_view, p;
  logic [5:0]  lc;
  dis_flags_t  flags;
  logic [31:0] loop_view;
  dis_mem_wr_t mem_wr;
  int          num_errors = 0;
  int          num_checks = 0;

  dis_exec DUT (.clk(clk), .rst(rst), .instr(instr), .resume(resume), .acc(acc),
    .product_upper(pu), .product_lower(pl), .pc(pc), .flags(flags), .lead_count(lc),
    .reg_view(reg_view), .loop_view(loop_view), .mem_wr(mem_wr), .halted(halted),
    .instr_ready(instr_ready));

  // one cycle idle between sends keeps valid from being driven twice per step
  task automatic send(dis_op_t op, logic [15:0] v = 16'h0, logic dw = 1'b0,
                      logic cnd = 1'b1, logic [5:0] sh = 6'h0, dis_src_t s = SRC_DIR,
                      logic up = 1'b0, logic uc = 1'b0);
    @(posedge clk);
    instr <= '{1'b1, op, s, 3'h0, v, v, sh, uc, cnd, dw, up, 1'b0};
    @(posedge clk);
    instr <= '0;
    #1;
  endtask

  task automatic t_add();
    send(OP_ZERO_OUT, 16'h0, 1'b1);
    `CHK(acc, 40'h0)
    send(OP_SUM_LITERAL, 16'h4000);
    send(OP_SUM_SIGNED_SHORT, 16'h0, 1'b0, 1'b1, 6'h3f);
    `CHK(acc, 40'h00_3fff_0000)
    for (int k = 1; k < 5; k++) begin
      send(OP_SUM, 16'h0001, 1'b0, 1'b1, 6'h0, dis_src_t'(k));
    end
    `CHK(acc, 40'h00_4003_0000)
    send(OP_COUNT_DOWN_REG);
    `CHK(reg_view, 16'hffff)
    send(OP_SUM, 16'h0, 1'b0, 1'b1, 6'h0, SRC_REG);
    `CHK(acc, 40'h00_4002_0000)
    send(OP_SUM_LITERAL, 16'h0, 1'b0, 1'b1, 6'h0, SRC_DIR, 1'b0, 1'b1);
    `CHK(acc, 40'h00_4002_0001)
    send(OP_ZERO_OUT_REG);
    `CHK(reg_view, 16'h0)
  endtask

  task automatic t_mask();
    send(OP_ZERO_OUT, 16'h0, 1'b1);
    send(OP_COUNT_DOWN_ACC, 16'h0, 1'b1);
    `CHK(acc, 40'hff_ffff_ffff)
    send(OP_MASK_LITERAL, 16'h0ff0);
    `CHK(acc, 40'hff_0ff0_ffff)
    send(OP_MASK_UNSIGNED_SHORT, 16'hffff, 1'b0, 1'b1, 6'h3c);
    `CHK(acc, 40'hff_0030_ffff)
    send(OP_COUNT_DOWN_ACC, 16'h0, 1'b1, 1'b0);
    `CHK(acc, 40'hff_0030_ffff)
  endtask

  task automatic t_flow();
    send(OP_JUMP_COND, 16'h0123);
    `CHK(pc, 16'h0123)
    send(OP_JUMP_COND, 16'h0456, 1'b0, 1'b0);
    `CHK(pc, 16'h0124)
    send(OP_CALL, 16'h0200);
    `CHK(pc, 16'h0200)
    send(OP_CALL, 16'h0300, 1'b0, 1'b0);
    `CHK(pc, 16'h0201)
    send(OP_LOOP_BRANCH_NONZERO, 16'h0400);
    `CHK({loop_view, pc}, {32'h0, 16'h0202})
  endtask

  task automatic t_halt();
    p = pc;
    send(OP_HALT);
    `CHK({halted, instr_ready, pc}, {2'b10, p})
    send(OP_ZERO_OUT, 16'h0, 1'b1);
    `CHK({acc, pc}, {40'hff_0030_ffff, p})
    @(posedge clk);
    resume <= 1'b1;
    @(posedge clk);
    resume <= 1'b0;
    #1;
    `CHK(instr_ready, 1'b1)
  endtask

  task automatic t_cmp();
    send(OP_ZERO_OUT, 16'h0, 1'b1);
    send(OP_SUM_LITERAL, 16'h1234);
    send(OP_COMPARE_OP, 16'h1234);
    `CHK({acc, flags.z, flags.n}, {40'h00_1234_0000, 2'b10})
    send(OP_COMPARE_OP, 16'h2000);
    `CHK({acc, flags.z, flags.n}, {40'h00_1234_0000, 2'b01})
    send(OP_PRODUCT_SUM, 16'h0003, 1'b0, 1'b1, 6'h0, SRC_DIR, 1'b1);
    send(OP_PRODUCT_SUM);
    `CHK(acc, 40'h00_1234_0009)
    `CHK({pu, pl}, 32'h0000_0009)
    send(OP_PRODUCT_SUBTRACT);
    `CHK(acc, 40'h00_1234_0000)
    send(OP_PRODUCT_COMPARE);
    `CHK(acc, 40'h00_1234_0000)
  endtask

  task automatic t_inv();
    send(OP_INVERT_ACC, 16'h0, 1'b1);
    `CHK(acc, 40'hff_edcb_ffff)
    send(OP_ABSOLUTE_VALUE, 16'h0, 1'b1);
    `CHK(acc, 40'h00_1234_0001)
    send(OP_INVERT_ACC, 16'h0, 1'b1, 1'b0);
    `CHK(acc, 40'h00_1234_0001)
    send(OP_LEADING_BIT_COUNT);
    `CHK(lc, 6'h0a)
    send(OP_COUNT_DOWN_MEM, 16'h0010);
    `CHK(mem_wr, {1'b1, 16'h000f})
    @(posedge clk);
    #1;
    `CHK(mem_wr.we, 1'b0)
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // whole run needs about 90 cycles
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    resume = 1'b0;
    instr = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_add();
    t_mask();
    t_flow();
    t_halt();
    t_cmp();
    t_inv();
    summarize();
  end
endmodule

// [src/dis_exec.sv]
/*
  execute stage of the fixed-point core: accumulator, product pair, pc,
  call stack, loop counters and the general registers.
  assumes the sequencer presents one decoded instruction per cycle with
  its memory or control operand already fetched, and writes memory back
  through mem_wr the next cycle.
*/
// Functional notes
// - register add into accumulator, optional carry
// - add takes memory, control, literal, short sources
// - mask ANDs source into upper word only
// - short mask literal is zero-extended
// - jump loads pc when condition holds
// - call pushes pc then jumps, conditional
// - halt stops execution for the debugger
// - count leading sign bits of accumulator
// - zero_out clears accumulator or a register
// - compare updates flags, accumulator untouched
// - invert accumulator bitwise on condition
// - product_sum adds product pair, may update
// - product_subtract subtracts product pair, may update
// - loop branch when selected counter nonzero
// - product_compare updates flags only
// - count_down decrements acc, register or memory
// - forty-bit accumulator: extension, upper, lower
// - words are two's-complement fractions
// - alu operand from source word or product
`timescale 1ns/1ns
`include "dis_params.svh"
module dis_exec #(
  parameter int NREGS       = `DIS_NREGS,
  parameter int STACK_DEPTH = `DIS_STACK_DEPTH
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire dis_pkg::dis_instr_t instr,
  input  wire logic               resume,
  output      logic [39:0]        acc,
  output      logic [15:0]        product_upper,
  output      logic [15:0]        product_lower,
  output      logic [15:0]        pc,
  output      dis_pkg::dis_flags_t flags,
  output      logic [5:0]         lead_count,
  output      logic [15:0]        reg_view,
  output      logic [31:0]        loop_view,
  output      dis_pkg::dis_mem_wr_t mem_wr,
  output      logic               halted,
  output      logic               instr_ready
);
  import dis_pkg::*;

  // the state struct is sized for eight registers and eight stack slots
  if (NREGS != 8 || STACK_DEPTH != 8) begin : g_bad_size
    $error("dis_exec supports eight registers and an eight-deep stack");
  end

  // the datapath slices assume a forty-bit frame with the word at bit 16
  if (`DIS_ACC_W != 40 || `DIS_EXT_LSB != 32 || `DIS_HI_LSB != 16
      || `DIS_SHORT_W != 6) begin : g_bad_frame
    $error("dis_exec is built for a forty-bit accumulator frame");
  end

  dis_state_s_t s_reg;
  dis_state_s_t s_next;

  // sign-extend a word into the forty-bit accumulator frame
  function automatic logic [39:0] ext_word(input logic [15:0] w);
    ext_word = {{8{w[15]}}, w, 16'h0000};
  endfunction

  function automatic logic [39:0] ext_dw(input logic [31:0] d);
    ext_dw = {{8{d[31]}}, d};
  endfunction

  // flags from a forty-bit result; carry out and overflow from the adder
  function automatic dis_flags_t mk_flags(input logic [40:0] r, input logic [39:0] a,
                                          input logic [39:0] b, input logic sub);
    dis_flags_t f;
    f.z = (r[39:0] == 40'h00_0000_0000);
    f.n = r[39];
    f.c = r[40];
    f.v = sub ? ((a[39] != b[39]) && (r[39] != a[39]))
              : ((a[39] == b[39]) && (r[39] != a[39]));
    mk_flags = f;
  endfunction

  logic [39:0] src_word;
  logic [39:0] prod_val;
  logic [40:0] sum_r;
  logic [40:0] diff_r;
  logic [39:0] dec_acc;
  logic [39:0] abs_acc;
  logic [5:0]  lbc;
  logic        running;
  logic        cond_op;

  assign running = (s_reg.state == ST_RUN);

  always_comb begin
    // operand chosen by source; register source reads the file
    src_word = (instr.src == SRC_REG) ? ext_word(s_reg.regs[instr.reg_sel])
                                      : ext_word(instr.operand);
    // literal forms never read the register file, whatever src says
    if (instr.op == OP_SUM_LITERAL || instr.op == OP_MASK_LITERAL) begin
      src_word = ext_word(instr.operand);
    end else if (instr.op == OP_SUM_SIGNED_SHORT) begin
      src_word = ext_word({{10{instr.short_literal[5]}}, instr.short_literal});
    end
  end

  // product pair joined as one double word
  assign prod_val = ext_dw({s_reg.product_upper, s_reg.product_lower});

  always_comb begin
    logic [39:0] b;
    logic        cin;
    b   = 40'h00_0000_0000;
    cin = 1'b0;
    case (instr.op)
      OP_PRODUCT_SUM, OP_PRODUCT_SUBTRACT, OP_PRODUCT_COMPARE: b = prod_val;
      default: b = src_word;
    endcase
    // the carry modifier belongs to the sum family only
    if (instr.op inside {OP_SUM, OP_SUM_LITERAL, OP_SUM_SIGNED_SHORT}) begin
      cin = instr.use_carry & s_reg.flags.c;
    end
    sum_r  = {1'b0, s_reg.acc} + {1'b0, b} + {40'h00_0000_0000, cin};
    diff_r = {1'b0, s_reg.acc} - {1'b0, b};
  end

  // single-width forms work on the upper word frame, double on whole acc
  always_comb begin
    logic [39:0] one;
    logic [23:0] upper_neg;
    one       = instr.double_width ? 40'h00_0000_0001 : 40'h00_0001_0000;
    upper_neg = 24'h00_0000 - s_reg.acc[39:16];
    dec_acc   = s_reg.acc - one;
    // the most negative value has no positive twin and comes back as is
    if (instr.double_width) begin
      abs_acc = s_reg.acc[39] ? (40'h00_0000_0000 - s_reg.acc) : s_reg.acc;
    end else begin
      abs_acc = s_reg.acc[39] ? {upper_neg, s_reg.acc[15:0]} : s_reg.acc;
    end
  end

  // bit i counts only while bits 38 down to i all match the sign bit
  logic [38:0] sign_run;
  assign sign_run[38] = (s_reg.acc[38] == s_reg.acc[39]);
  for (genvar i = 0; i < 38; i++) begin : g_lead
    assign sign_run[i] = sign_run[i+1] && (s_reg.acc[i] == s_reg.acc[39]);
  end

  always_comb begin
    lbc = 6'h00;
    for (int i = 0; i < 39; i++) begin
      lbc = lbc + {5'h00, sign_run[i]};
    end
  end

  // ops that carry a condition; every other op ignores cond_ok
  always_comb begin
    case (instr.op)
      OP_JUMP_COND, OP_CALL, OP_INVERT_ACC, OP_PRODUCT_SUM, OP_PRODUCT_SUBTRACT,
      OP_COUNT_DOWN_ACC, OP_COUNT_DOWN_REG, OP_COUNT_DOWN_MEM,
      OP_ABSOLUTE_VALUE: cond_op = 1'b1;
      default:           cond_op = 1'b0;
    endcase
  end

  always_comb begin
    logic go;
    s_next        = s_reg;
    s_next.mem_wr = '0;
    go = 1'b0;
    case (s_reg.state)
      ST_RUN: begin
        if (instr.valid) begin
          s_next.pc = s_reg.pc + 16'h0001;
          // conditional ops do nothing but advance when false
          go = !cond_op || instr.cond_ok;
          case (instr.op)
            OP_SUM, OP_SUM_LITERAL, OP_SUM_SIGNED_SHORT: begin
              s_next.acc   = sum_r[39:0];
              s_next.flags = mk_flags(sum_r, s_reg.acc, src_word, 1'b0);
            end
            OP_MASK, OP_MASK_LITERAL: begin
              s_next.acc[31:16] = s_reg.acc[31:16] & src_word[31:16];
            end
            OP_MASK_UNSIGNED_SHORT: begin
              s_next.acc[31:16] = s_reg.acc[31:16] & {10'h000, instr.short_literal};
            end
            OP_JUMP_COND: begin
              if (go) begin
                s_next.pc = instr.program_target;
              end
            end
            OP_CALL: begin
              if (go) begin
                // eight slots: a ninth nested call overwrites the oldest
                s_next.stack[s_reg.sp] = s_reg.pc;
                s_next.sp = s_reg.sp + 3'h1;
                s_next.pc = instr.program_target;
              end
            end
            OP_HALT: begin
              s_next.state = ST_HALTED;
              // pc holds so resume restarts at the halt's own address
              s_next.pc    = s_reg.pc;
            end
            OP_LEADING_BIT_COUNT: begin
              s_next.lead_count = lbc;
            end
            OP_ZERO_OUT: begin
              if (instr.double_width) begin
                s_next.acc = 40'h00_0000_0000;
              end else begin
                s_next.acc = {s_reg.acc[39:32], 32'h0000_0000};
                s_next.acc[39:32] = 8'h00;
              end
            end
            OP_ZERO_OUT_REG: begin
              s_next.regs[instr.reg_sel] = 16'h0000;
            end
            OP_COMPARE_OP: begin
              s_next.flags = mk_flags(diff_r, s_reg.acc, src_word, 1'b1);
            end
            OP_INVERT_ACC: begin
              if (go) begin
                s_next.acc = instr.double_width ? ~s_reg.acc
                           : {~s_reg.acc[39:16], s_reg.acc[15:0]};
              end
            end
            // product update squares the operand, a stand-in for the multiplier
            OP_PRODUCT_SUM: begin
              if (go) begin
                s_next.acc   = sum_r[39:0];
                s_next.flags = mk_flags(sum_r, s_reg.acc, prod_val, 1'b0);
                if (instr.update_product) begin
                  {s_next.product_upper, s_next.product_lower} = instr.operand * instr.operand;
                end
              end
            end
            OP_PRODUCT_SUBTRACT: begin
              if (go) begin
                s_next.acc   = diff_r[39:0];
                s_next.flags = mk_flags(diff_r, s_reg.acc, prod_val, 1'b1);
                if (instr.update_product) begin
                  {s_next.product_upper, s_next.product_lower} = instr.operand * instr.operand;
                end
              end
            end
            OP_PRODUCT_COMPARE: begin
              s_next.flags = mk_flags(diff_r, s_reg.acc, prod_val, 1'b1);
            end
            OP_LOOP_BRANCH_NONZERO: begin
              if (s_reg.loop_counters[instr.loop_sel] != 16'h0000) begin
                s_next.pc = instr.program_target;
                s_next.loop_counters[instr.loop_sel] =
                  s_reg.loop_counters[instr.loop_sel] - 16'h0001;
              end
            end
            OP_COUNT_DOWN_ACC: begin
              if (go) begin
                s_next.acc = dec_acc;
              end
            end
            OP_COUNT_DOWN_REG: begin
              if (go) begin
                s_next.regs[instr.reg_sel] = s_reg.regs[instr.reg_sel] - 16'h0001;
              end
            end
            OP_COUNT_DOWN_MEM: begin
              if (go) begin
                s_next.mem_wr.we   = 1'b1;
                s_next.mem_wr.data = instr.operand - 16'h0001;
              end
            end
            OP_ABSOLUTE_VALUE: begin
              if (go) begin
                s_next.acc = abs_acc;
              end
            end
            default: begin
              s_next.pc = s_reg.pc + 16'h0001;
            end
          endcase
        end
      end
      ST_HALTED: begin
        // frozen until the debugger lets go
        if (resume) begin
          s_next.state = ST_RUN;
        end
      end
      default: s_next.state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg.state         <= ST_RUN;
      s_reg.acc           <= `DIS_ACC_RESET;
      s_reg.product_upper <= `DIS_PROD_RESET;
      s_reg.product_lower <= `DIS_PROD_RESET;
      s_reg.pc            <= `DIS_PC_RESET;
      s_reg.flags         <= `DIS_FLAG_RESET;
      // walk the file and stack so each slot takes its reset word
      for (int i = 0; i < 8; i++) begin
        s_reg.regs[i]  <= `DIS_REG_RESET;
        s_reg.stack[i] <= `DIS_REG_RESET;
      end
      s_reg.sp            <= 3'h0;
      for (int j = 0; j < 2; j++) begin
        s_reg.loop_counters[j] <= `DIS_LOOP_RESET;
      end
      s_reg.lead_count    <= 6'h00;
      s_reg.mem_wr        <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign acc           = s_reg.acc;
  assign product_upper = s_reg.product_upper;
  assign product_lower = s_reg.product_lower;
  assign pc            = s_reg.pc;
  assign flags         = s_reg.flags;
  assign lead_count    = s_reg.lead_count;
  // read follows reg_sel in the same cycle, no register in between
  assign reg_view      = s_reg.regs[instr.reg_sel];
  assign loop_view     = {s_reg.loop_counters[1], s_reg.loop_counters[0]};
  assign mem_wr        = s_reg.mem_wr;
  assign halted        = ~running;
  // sequencer must hold issue while halted
  assign instr_ready   = running;
endmodule

// [src/dis_params.svh]
/*
  timing-free constants for the instruction execute datapath.
  assumes inclusion by dis_pkg and the execute module only.
*/
`ifndef DIS_PARAMS_SVH
`define DIS_PARAMS_SVH
`define DIS_ACC_RESET    40'h00_0000_0000
`define DIS_PROD_RESET   16'h0000
`define DIS_PC_RESET     16'h0000
`define DIS_REG_RESET    16'h0000
`define DIS_LOOP_RESET   16'h0000
`define DIS_ACC_W        40
`define DIS_EXT_LSB      32
`define DIS_HI_LSB       16
`define DIS_NREGS        8
`define DIS_STACK_DEPTH  8
`define DIS_SHORT_W      6
`define DIS_FLAG_RESET   4'h0
`endif

// [src/dis_pkg.sv]
/*
  types for the instruction execute datapath.
  assumes the params header defines all numeric constants.
*/
`include "dis_params.svh"
package dis_pkg;
  typedef enum logic [4:0] {
    OP_NOP          = 5'h00,
    OP_SUM          = 5'h01,
    OP_SUM_LITERAL  = 5'h02,
    OP_SUM_SIGNED_SHORT = 5'h03,
    OP_MASK         = 5'h04,
    OP_MASK_LITERAL = 5'h05,
    OP_MASK_UNSIGNED_SHORT = 5'h06,
    OP_JUMP_COND    = 5'h07,
    OP_CALL         = 5'h08,
    OP_HALT         = 5'h09,
    OP_LEADING_BIT_COUNT = 5'h0a,
    OP_ZERO_OUT     = 5'h0b,
    OP_ZERO_OUT_REG = 5'h0c,
    OP_COMPARE_OP   = 5'h0d,
    OP_INVERT_ACC   = 5'h0e,
    OP_PRODUCT_SUM  = 5'h0f,
    OP_PRODUCT_SUBTRACT = 5'h10,
    OP_PRODUCT_COMPARE  = 5'h11,
    OP_LOOP_BRANCH_NONZERO = 5'h12,
    OP_COUNT_DOWN_ACC = 5'h13,
    OP_COUNT_DOWN_REG = 5'h14,
    OP_COUNT_DOWN_MEM = 5'h15,
    OP_ABSOLUTE_VALUE = 5'h16
  } dis_op_t;

  typedef enum logic [2:0] {
    SRC_REG   = 3'h0,
    SRC_PTR   = 3'h1,
    SRC_DIR   = 3'h2,
    SRC_PROG  = 3'h3,
    SRC_CFG   = 3'h4
  } dis_src_t;

  typedef enum logic [1:0] {
    ST_RUN    = 2'h0,
    ST_HALTED = 2'h1
  } dis_state_t;

  // one instruction as issued by the sequencer, operands already fetched
  typedef struct packed {
    logic       valid;
    dis_op_t    op;
    dis_src_t   src;
    logic [2:0] reg_sel;
    logic [15:0] operand;
    logic [15:0] program_target;
    logic [5:0] short_literal;
    logic       use_carry;
    logic       cond_ok;
    logic       double_width;
    logic       update_product;
    logic       loop_sel;
  } dis_instr_t;

  // condition state: zero, negative, carry, overflow
  typedef struct packed {
    logic z;
    logic n;
    logic c;
    logic v;
  } dis_flags_t;

  typedef struct packed {
    logic        we;
    logic [15:0] data;
  } dis_mem_wr_t;

  typedef struct packed {
    dis_state_t  state;
    logic [39:0] acc;
    logic [15:0] product_upper;
    logic [15:0] product_lower;
    logic [15:0] pc;
    dis_flags_t  flags;
    logic [7:0][15:0] regs;
    logic [7:0][15:0] stack;
    logic [2:0]  sp;
    logic [1:0][15:0] loop_counters;
    logic [5:0]  lead_count;
    dis_mem_wr_t mem_wr;
  } dis_state_s_t;
endpackage
